// File: hdl/lec_lookup_ctrl.sv
// Purpose: lookup engine control registers one and two, the aging period register and the datapath they steer
// Assumes: single 10 MHz core clock, synchronous active-high reset
// Notes:   register port is a plain byte write/read at documented addresses
module lec_lookup_ctrl #(
  parameter int PORTS     = 7,
  parameter int PRIO_W    = 3,
  parameter int AGE_CNT_W = 3
) (
  input  wire logic                       i_core_clk,
  input  wire logic                       i_reset,
  // register port
  input  wire logic [15:0]                i_reg_addr,
  input  wire logic                       i_reg_wr,
  input  wire logic                       i_reg_rd,
  input  wire logic [7:0]                 i_reg_wdata,
  output logic      [7:0]                 o_reg_rdata,
  output logic                            o_reg_hit,
  // configuration from outside
  input  wire logic                       i_double_tag_en,
  input  wire logic [PORTS-1:0]           i_host_port_map,
  // lookup result
  input  wire logic                       i_reserved_mcast,
  input  wire logic                       i_hit_dynamic,
  input  wire logic                       i_hit_static,
  input  wire logic [PORTS-1:0]           i_entry_map,
  input  wire logic [PORTS-1:0]           i_vlan_map,
  input  wire logic [PORTS-1:0]           i_normal_map,
  output logic      [PORTS-1:0]           o_egress_map,
  // address table priority
  input  wire logic [PRIO_W-1:0]          i_dest_prio,
  input  wire logic [PRIO_W-1:0]          i_src_prio,
  output logic      [PRIO_W-1:0]          o_address_table_priority,
  // aging
  input  wire logic [AGE_CNT_W-1:0]       i_age_count,
  output logic      [7:0]                 o_aging_period,
  output logic      [AGE_CNT_W+7:0]       o_aging_time_sec,
  // flush engine handshake
  input  wire logic                       i_flush_done,
  output logic                            o_flush_start,
  output logic                            o_flush_multi_spanning_tree,
  output logic                            o_flush_dynamic,
  output logic                            o_flush_static,
  output logic                            o_flush_busy
);
  import lec_pkg::*;

  logic [7:0]          ctrl2_q;
  logic [7:0]          aging_q;
  logic                trig_all_q;
  logic                trig_mst_q;
  logic                start_q;
  lec_flush_state_type state_q;
  logic [PORTS-1:0]    dyn_map;
  logic [PORTS-1:0]    sta_map;
  logic [PORTS-1:0]    egress_d;
  logic [PRIO_W-1:0]   prio_d;
  logic [1:0]          flush_sel;
  logic                wr_ctrl1;
  logic                wr_ctrl2;

  assign wr_ctrl1  = i_reg_wr && (i_reg_addr == LEC_CTRL1_ADDR);
  assign wr_ctrl2  = i_reg_wr && (i_reg_addr == LEC_CTRL2_ADDR);
  assign flush_sel = ctrl2_q[LEC_FLUSH_HI:LEC_FLUSH_LO];

  // control register two; flush selection returns to none once a flush ends
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      ctrl2_q <= LEC_CTRL2_RESET;
    end else if (wr_ctrl2) begin
      ctrl2_q <= i_reg_wdata;
    end else if (state_q != LEC_IDLE && i_flush_done) begin
      ctrl2_q[LEC_FLUSH_HI:LEC_FLUSH_LO] <= LEC_FLUSH_NONE;
    end
  end

  // aging period register
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      aging_q <= LEC_AGING_RESET;
    end else if (i_reg_addr == LEC_AGING_ADDR && i_reg_wr) begin
      aging_q <= i_reg_wdata;
    end
  end

  // flush triggers: set by a write of 1, cleared when the flush finishes
  // a new trigger write in the done cycle wins so the request is not lost
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      trig_all_q <= 1'b0;
      trig_mst_q <= 1'b0;
    end else begin
      if (wr_ctrl1 && i_reg_wdata[LEC_FLUSH_ALL_BIT]) begin
        trig_all_q <= 1'b1;
      end else if (state_q == LEC_TABLE && i_flush_done) begin
        trig_all_q <= 1'b0;
      end
      if (wr_ctrl1 && i_reg_wdata[LEC_FLUSH_MST_BIT]) begin
        trig_mst_q <= 1'b1;
      end else if (state_q == LEC_SPAN && i_flush_done) begin
        trig_mst_q <= 1'b0;
      end
    end
  end

  // flush sequencer; table flush has priority over spanning tree flush
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      state_q <= LEC_IDLE;
      start_q <= 1'b0;
    end else begin
      start_q <= 1'b0;
      unique case (state_q)
        LEC_IDLE: begin
          if (trig_all_q) begin
            state_q <= LEC_TABLE;
            start_q <= 1'b1;
          end else if (trig_mst_q) begin
            state_q <= LEC_SPAN;
            start_q <= 1'b1;
          end
        end
        LEC_TABLE, LEC_SPAN: begin
          if (i_flush_done) begin
            state_q <= LEC_IDLE;
          end
        end
        default: state_q <= LEC_IDLE;
      endcase
    end
  end

  // selection steers which entry kinds the flush engine may remove
  assign o_flush_start               = start_q;
  assign o_flush_busy                = (state_q != LEC_IDLE);
  assign o_flush_multi_spanning_tree = (state_q == LEC_SPAN);
  assign o_flush_dynamic = flush_sel == LEC_FLUSH_DYNAMIC
                        || flush_sel == LEC_FLUSH_BOTH;
  assign o_flush_static  = flush_sel == LEC_FLUSH_STATIC
                        || flush_sel == LEC_FLUSH_BOTH;

  // one filter per entry kind
  lec_port_filter #(.PORTS(PORTS)) u_dyn_filter (
    .i_filter_en (ctrl2_q[LEC_DYN_FILT_BIT]),
    .i_entry_map (i_entry_map),
    .i_vlan_map  (i_vlan_map),
    .o_port_map  (dyn_map)
  );

  lec_port_filter #(.PORTS(PORTS)) u_sta_filter (
    .i_filter_en (ctrl2_q[LEC_STA_FILT_BIT]),
    .i_entry_map (i_entry_map),
    .i_vlan_map  (i_vlan_map),
    .o_port_map  (sta_map)
  );

  // egress selection; trap overrides any address hit
  always_comb begin
    if (ctrl2_q[LEC_TRAP_BIT] && i_double_tag_en && i_reserved_mcast) begin
      egress_d = i_host_port_map;
    end else if (i_hit_static) begin
      egress_d = sta_map;
    end else if (i_hit_dynamic) begin
      egress_d = dyn_map;
    end else begin
      egress_d = i_normal_map;
    end
  end

  // priority source selection
  always_comb begin
    unique case (ctrl2_q[LEC_PRIO_HI:LEC_PRIO_LO])
      LEC_PRIO_DEST:   prio_d = i_dest_prio;
      LEC_PRIO_SRC:    prio_d = i_src_prio;
      LEC_PRIO_HIGHER: prio_d = (i_dest_prio > i_src_prio) ? i_dest_prio : i_src_prio;
      LEC_PRIO_LOWER:  prio_d = (i_dest_prio < i_src_prio) ? i_dest_prio : i_src_prio;
    endcase
  end

  // registered datapath outputs, one cycle after the lookup inputs
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      o_egress_map             <= '0;
      o_address_table_priority <= '0;
      o_aging_time_sec         <= '0;
    end else begin
      o_egress_map             <= egress_d;
      o_address_table_priority <= prio_d;
      // both operands widened on purpose so the product keeps every bit
      o_aging_time_sec         <= (AGE_CNT_W+8)'(aging_q)
                                * (AGE_CNT_W+8)'(i_age_count);
    end
  end

  assign o_aging_period = aging_q;

  // read data registered; unmapped addresses read zero with hit low
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      o_reg_rdata <= 8'h00;
      o_reg_hit   <= 1'b0;
    end else begin
      o_reg_hit   <= 1'b0;
      o_reg_rdata <= 8'h00;
      if (i_reg_rd) begin
        unique case (i_reg_addr)
          LEC_CTRL1_ADDR: begin
            o_reg_rdata <= {2'b00, trig_all_q, trig_mst_q, 4'h0};
            o_reg_hit   <= 1'b1;
          end
          LEC_CTRL2_ADDR: begin
            o_reg_rdata <= ctrl2_q;
            o_reg_hit   <= 1'b1;
          end
          LEC_AGING_ADDR: begin
            o_reg_rdata <= aging_q;
            o_reg_hit   <= 1'b1;
          end
          default: begin
            o_reg_rdata <= 8'h00;
          end
        endcase
      end
    end
  end
endmodule // lec_lookup_ctrl

// File: hdl/lec_pkg.sv
// Purpose: constants shared by the lookup engine control registers
// Assumes: byte-wide register port, 16-bit register addresses
// Notes:   offsets, field positions and reset values live here
package lec_pkg;
  localparam logic [15:0] LEC_CTRL2_ADDR     = 16'h0312;
  localparam logic [15:0] LEC_AGING_ADDR     = 16'h0313;
  localparam logic [15:0] LEC_CTRL1_ADDR     = 16'h0311;
  localparam int          LEC_TRAP_BIT       = 6;
  localparam int          LEC_DYN_FILT_BIT   = 5;
  localparam int          LEC_STA_FILT_BIT   = 4;
  localparam int          LEC_FLUSH_HI       = 3;
  localparam int          LEC_FLUSH_LO       = 2;
  localparam int          LEC_PRIO_HI        = 1;
  localparam int          LEC_PRIO_LO        = 0;
  localparam int          LEC_FLUSH_ALL_BIT  = 5;
  localparam int          LEC_FLUSH_MST_BIT  = 4;
  localparam logic [7:0]  LEC_CTRL2_RESET    = 8'h00;
  localparam logic [7:0]  LEC_AGING_RESET    = 8'h4B;
  localparam logic [1:0]  LEC_FLUSH_NONE     = 2'h0;
  localparam logic [1:0]  LEC_FLUSH_DYNAMIC  = 2'h1;
  localparam logic [1:0]  LEC_FLUSH_STATIC   = 2'h2;
  localparam logic [1:0]  LEC_FLUSH_BOTH     = 2'h3;
  localparam logic [1:0]  LEC_PRIO_DEST      = 2'h0;
  localparam logic [1:0]  LEC_PRIO_SRC       = 2'h1;
  localparam logic [1:0]  LEC_PRIO_HIGHER    = 2'h2;
  localparam logic [1:0]  LEC_PRIO_LOWER     = 2'h3;

  typedef enum logic [2:0] {
    LEC_IDLE  = 3'b001,
    LEC_TABLE = 3'b010,
    LEC_SPAN  = 3'b100
  } lec_flush_state_type;
endpackage : lec_pkg

// File: hdl/lec_port_filter.sv
// Purpose: egress port set for one kind of address entry hit
// Assumes: port maps are one bit per port
// Notes:   instantiated once for dynamic and once for static hits
module lec_port_filter #(
  parameter int PORTS = 7
) (
  input  wire logic             i_filter_en,
  input  wire logic [PORTS-1:0] i_entry_map,
  input  wire logic [PORTS-1:0] i_vlan_map,
  output logic      [PORTS-1:0] o_port_map
);
  // vlan map only narrows the entry map, never widens it
  assign o_port_map = i_filter_en ? (i_entry_map & i_vlan_map) : i_entry_map;
endmodule // lec_port_filter

// File: tb/lec_lookup_ctrl_chk.sv
// Purpose: concurrent checks on the lookup control register ports
// Assumes: one clock domain, synchronous active-high reset
// Notes:   register contents are judged through reads and flush outputs
module lec_lookup_ctrl_chk import lec_pkg::*; #(
  parameter int AGE_CNT_W = 3
) (
  input wire logic                 i_core_clk,
  input wire logic                 i_reset,
  input wire logic [15:0]          i_reg_addr,
  input wire logic                 i_reg_wr,
  input wire logic                 i_reg_rd,
  input wire logic [7:0]           i_reg_wdata,
  input wire logic [7:0]           o_reg_rdata,
  input wire logic                 o_reg_hit,
  input wire logic [AGE_CNT_W-1:0] i_age_count,
  input wire logic [7:0]           o_aging_period,
  input wire logic [AGE_CNT_W+7:0] o_aging_time_sec,
  input wire logic                 i_flush_done,
  input wire logic                 o_flush_start,
  input wire logic                 o_flush_multi_spanning_tree,
  input wire logic                 o_flush_dynamic,
  input wire logic                 o_flush_static,
  input wire logic                 o_flush_busy
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_reset);
  // trigger write while idle; a trigger still pending is not visible here
  sequence s_trig_wr;
    i_reg_wr && i_reg_addr == LEC_CTRL1_ADDR && !o_flush_busy
      && (i_reg_wdata[LEC_FLUSH_ALL_BIT] || i_reg_wdata[LEC_FLUSH_MST_BIT]);
  endsequence
  AST_RD_MAP: assert property (
    i_reg_rd && i_reg_addr inside {[LEC_CTRL1_ADDR:LEC_AGING_ADDR]} |=> o_reg_hit)
    else $error("mapped read gave no hit");
  AST_RD_UNMAP: assert property (
    i_reg_rd && !(i_reg_addr inside {[LEC_CTRL1_ADDR:LEC_AGING_ADDR]})
    |=> !o_reg_hit && o_reg_rdata == 8'h00) else $error("unmapped read answered");
  AST_RD_IDLE: assert property (!i_reg_rd |=> o_reg_rdata == 8'h00 && !o_reg_hit)
    else $error("read data without a read");
  AST_RD_AGE: assert property (
    i_reg_rd && i_reg_addr == LEC_AGING_ADDR |=> o_reg_rdata == $past(o_aging_period))
    else $error("aging read differs from aging output");
  AST_AGE_TIME: assert property (
    1'b1 |=> o_aging_time_sec == $past(o_aging_period) * $past(i_age_count))
    else $error("aging time is not period times count");
  AST_TRIG: assert property (
    s_trig_wr |-> ##2 (o_flush_start
      && o_flush_multi_spanning_tree == !$past(i_reg_wdata[LEC_FLUSH_ALL_BIT], 2)))
    else $error("flush trigger did not start the right flush");
  AST_PULSE: assert property (o_flush_start |-> o_flush_busy ##1 !o_flush_start)
    else $error("flush start is not a single pulse");
  AST_BUSY_HOLD: assert property (o_flush_busy && !i_flush_done |=> o_flush_busy)
    else $error("flush busy dropped early");
  AST_DONE_CLR: assert property (
    o_flush_busy && i_flush_done && !(i_reg_wr && i_reg_addr == LEC_CTRL2_ADDR)
    |=> !o_flush_busy && !o_flush_dynamic && !o_flush_static)
    else $error("finished flush left selection set");
endmodule // lec_lookup_ctrl_chk

bind lec_lookup_ctrl lec_lookup_ctrl_chk #(.AGE_CNT_W(AGE_CNT_W)) u_chk (
  .i_core_clk, .i_reset, .i_reg_addr, .i_reg_wr, .i_reg_rd, .i_reg_wdata, .o_reg_rdata,
  .o_reg_hit, .i_age_count, .o_aging_period, .o_aging_time_sec, .i_flush_done,
  .o_flush_start, .o_flush_multi_spanning_tree, .o_flush_dynamic, .o_flush_static,
  .o_flush_busy);

// File: tb/tb.sv
// Purpose: self-checking bench for the lookup engine control registers
// Assumes: requests taken on the rising edge, answers one cycle later
// Notes:   inputs move 1 ns after the edge so sampling never races
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import lec_pkg::*;
  logic        clk = 0, rst = 1, wr = 0, rd = 0, dt = 0, mc = 0, hd = 0, hs = 0, done = 0;
  logic [15:0] addr = 16'h0000;
  logic [7:0]  wdata = 8'h00, rdata, aging;
  logic [6:0]  ent = 7'h3c, vlan = 7'h0f, norm = 7'h41, hp = 7'h01, egress;
  logic [2:0]  dp = 3'h5, sp = 3'h2, agec = 3'h3, prio;
  logic [10:0] age_t;
  logic        hit, fstart, fmst, fdyn, fsta, fbusy;
  int          failures = 0, tests_run = 0;

  lec_lookup_ctrl DUT (.i_core_clk(clk), .i_reset(rst), .i_reg_addr(addr), .i_reg_wr(wr),
    .i_reg_rd(rd), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_hit(hit),
    .i_double_tag_en(dt), .i_host_port_map(hp), .i_reserved_mcast(mc), .i_hit_dynamic(hd),
    .i_hit_static(hs), .i_entry_map(ent), .i_vlan_map(vlan), .i_normal_map(norm),
    .o_egress_map(egress), .i_dest_prio(dp), .i_src_prio(sp), .o_address_table_priority(prio),
    .i_age_count(agec), .o_aging_period(aging), .o_aging_time_sec(age_t), .i_flush_done(done),
    .o_flush_start(fstart), .o_flush_multi_spanning_tree(fmst), .o_flush_dynamic(fdyn),
    .o_flush_static(fsta), .o_flush_busy(fbusy));

  // free-running core clock
  initial begin
    forever #50 clk = ~clk;
  end

  task automatic end_sim;
    if (failures == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic step;
    @(posedge clk);
    #1;
  endtask

  // trailing step keeps a strobe low for one edge between requests
  task automatic reg_wr(input logic [15:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr = 1;
    step();
    wr = 0;
    step();
  endtask

  task automatic reg_rd(input logic [15:0] a, input logic [7:0] exp, input logic h);
    addr = a;
    rd = 1;
    step();
    rd = 0;
    chk(rdata, exp);
    chk(hit, h);
    step();
  endtask

  task automatic eg(input logic d_hit, s_hit, m, t, input logic [6:0] exp);
    hd = d_hit;
    hs = s_hit;
    mc = m;
    dt = t;
    step();
    chk(egress, exp);
  endtask

  // whole flush: start, pending trigger readback, done, selection cleared
  task automatic flush(input logic [7:0] sel_wr, trig, input logic [1:0] sel);
    reg_wr(LEC_CTRL2_ADDR, sel_wr);
    reg_wr(LEC_CTRL1_ADDR, trig);
    chk({fstart, fbusy, fmst, fdyn, fsta}, {2'h3, trig[4], sel});
    reg_rd(LEC_CTRL1_ADDR, trig, 1);
    chk({fstart, fbusy}, 2'h1);
    done = 1;
    step();
    done = 0;
    chk({fbusy, fdyn, fsta}, 3'h0);
    reg_rd(LEC_CTRL2_ADDR, 8'h00, 1);
    reg_rd(LEC_CTRL1_ADDR, 8'h00, 1);
  endtask

  // watchdog, far beyond the roughly 115 cycles the tests need
  initial begin
    #200000;
    failures++;
    end_sim();
  end

  initial begin
    repeat (16) @(posedge clk);
    #1;
    rst = 0;
    chk(aging, 8'h4b);
    reg_rd(LEC_CTRL2_ADDR, 8'h00, 1);
    reg_rd(LEC_AGING_ADDR, 8'h4b, 1);
    reg_rd(16'h0314, 8'h00, 0);
    chk(age_t, 11'h0e1);
    reg_wr(LEC_AGING_ADDR, 8'h10);
    agec = 3'h5;
    step();
    chk(age_t, 11'h050);
    reg_rd(LEC_AGING_ADDR, 8'h10, 1);
    // swap priorities so every mode gives a distinct answer once
    for (int k = 0; k < 2; k++) begin
      dp = k ? 3'h2 : 3'h5;
      sp = k ? 3'h5 : 3'h2;
      for (int m = 0; m < 4; m++) begin
        reg_wr(LEC_CTRL2_ADDR, 8'(m));
        chk(prio, m == 0 ? dp : m == 1 ? sp : m == 2 ? 3'h5 : 3'h2);
      end
    end
    reg_wr(LEC_CTRL2_ADDR, 8'h20);
    eg(1, 0, 0, 0, 7'h0c);
    eg(0, 1, 0, 0, 7'h3c);
    reg_wr(LEC_CTRL2_ADDR, 8'h10);
    eg(1, 0, 0, 0, 7'h3c);
    eg(0, 1, 0, 0, 7'h0c);
    reg_wr(LEC_CTRL2_ADDR, 8'h40);
    eg(0, 1, 1, 1, 7'h01);
    // a second host map proves the trap follows the input, not a fixed port
    hp = 7'h22;
    eg(0, 0, 1, 1, 7'h22);
    eg(0, 1, 1, 0, 7'h3c);
    eg(0, 0, 0, 1, 7'h41);
    reg_wr(LEC_CTRL2_ADDR, 8'hb5);
    reg_rd(LEC_CTRL2_ADDR, 8'hb5, 1);
    eg(0, 1, 1, 1, 7'h0c);
    flush(8'h04, 8'h20, 2'h2);
    flush(8'h08, 8'h10, 2'h1);
    flush(8'h0c, 8'h20, 2'h3);
    // both triggers in one write: table flush first, spanning tree queued
    reg_wr(LEC_CTRL2_ADDR, 8'h0c);
    reg_wr(LEC_CTRL1_ADDR, 8'h30);
    chk({fstart, fbusy, fmst}, 3'h6);
    done = 1;
    step();
    done = 0;
    step();
    chk({fstart, fbusy, fmst, fdyn, fsta}, 5'h1c);
    reg_rd(LEC_CTRL1_ADDR, 8'h10, 1);
    done = 1;
    step();
    done = 0;
    chk(fbusy, 1'b0);
    reg_rd(LEC_CTRL1_ADDR, 8'h00, 1);
    // a reset in mid-run must bring back the defaults over written values
    reg_wr(LEC_CTRL2_ADDR, 8'h30);
    rst = 1;
    repeat (2) step();
    rst = 0;
    reg_rd(LEC_CTRL2_ADDR, 8'h00, 1);
    reg_rd(LEC_AGING_ADDR, 8'h4b, 1);
    end_sim();
  end
endmodule // tb
